// >>> port_io_map.vh
// register addresses, field positions and reset values for the port i/o block
`ifndef PORT_IO_MAP_VH
`define PORT_IO_MAP_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_PORT0_DATA 8'h80
`define ADDR_PORT1_DATA 8'h90
`define ADDR_PORT2_DATA 8'hA0
`define ADDR_PORT_STRIDE 8'h10
`define ADDR_XBAR_CTRL_B 8'hE2
`define ADDR_P0_MATCH_VAL 8'hD7
`define ADDR_P0_MATCH_MASK 8'hD8
`define ADDR_P1_MATCH_VAL 8'hD9
`define ADDR_P1_MATCH_MASK 8'hDA
`define ADDR_EXT_IE_2 8'hE7

// ----------------------------------------
// crossbar_route_ctrl_b fields
// ----------------------------------------
`define XB_WEAK_PULLUP_DIS 7
`define XB_CROSSBAR_EN 6
`define XB_TIMER1_EN 5
`define XB_TIMER0_EN 4
`define XB_ECI_EN 3
`define XB_CEX_CNT_HI 2
`define XB_CEX_CNT_LO 0
`define XB_CEX_CNT_RSVD 3'h7

// ----------------------------------------
// ext_interrupt_enable_2 fields
// ----------------------------------------
`define IE2_MATCH_IE 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_XBAR_CTRL_B 8'h00
`define RST_PORT_LATCH 8'hFF
`define RST_MATCH_VAL 8'hFF
`define RST_MATCH_MASK 8'h00
`define RST_EXT_IE_2 8'h00
`define RST_ZERO8 8'h00

`endif

// >>> pin_sync.v
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // asynchronous pins
  input wire [WIDTH-1:0] pin_i,
  // synchronised levels
  output reg [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge core_clk_i) begin
        if (rst_i) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          s1_reg[g] <= pin_i[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            level_o[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate

endmodule

// >>> port_io_latch_and_match.v
// port latches, pin readback, crossbar control register and port match detection
`timescale 1ns/1ps
`include "port_io_map.vh"

// Function
// - unclaimed non-analog pins act as software gpio
// - port registers byte and bit accessible
// - port write stored and held in latch
// - plain read returns sampled pin levels
// - read-modify-write reads latch, not pins
// - single-bit writes merge into latch value
// - masked port0 pins differ from match raises event
// - masked port1 mismatch also raises, ored
// - match uses real pins ignoring crossbar
// - match interrupt only when enable bit set
// - match event wakes suspended oscillator
// - crossbar enable off disables all drivers
// - weak pullups on open-drain unless disabled
module port_io_latch_and_match #(
  parameter NPORT = 3
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // special function register bus
  input wire [7:0] sfr_addr_i,
  input wire sfr_rd_i,
  input wire sfr_rmw_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_bit_wr_i,
  input wire [2:0] sfr_bit_sel_i,
  input wire sfr_bit_val_i,
  output reg [7:0] sfr_rdata_o,
  // pin configuration and crossbar peripheral claims
  input wire [8*NPORT-1:0] pin_pushpull_i,
  input wire [8*NPORT-1:0] pin_analog_i,
  input wire [8*NPORT-1:0] periph_claim_i,
  input wire [8*NPORT-1:0] periph_out_i,
  // package pins
  input wire [8*NPORT-1:0] pin_in_i,
  output reg [8*NPORT-1:0] pin_out_o,
  output reg [8*NPORT-1:0] pin_oe_o,
  output reg [8*NPORT-1:0] pullup_en_o,
  // crossbar routing controls
  output reg crossbar_enable_o,
  output reg timer0_pin_enable_o,
  output reg timer1_pin_enable_o,
  output reg counter_ext_input_enable_o,
  output reg [5:0] capture_compare_route_o,
  // match event outputs
  output reg match_irq_o,
  output reg osc_wake_o
);

  localparam W = 8 * NPORT;

  reg [W-1:0] latch_reg;
  reg [7:0] crossbar_route_ctrl_b_reg;
  reg [7:0] port0_match_value_reg;
  reg [7:0] port0_match_mask_reg;
  reg [7:0] port1_match_value_reg;
  reg [7:0] port1_match_mask_reg;
  reg [7:0] ext_interrupt_enable_2_reg;
  wire [W-1:0] pin_level;

  // ----------------------------------------
  // pin input synchronisation
  // ----------------------------------------
  pin_sync #(
    .WIDTH(W)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(pin_in_i),
    .level_o(pin_level)
  );

  // analog pins read back as zero
  wire [W-1:0] pin_read = pin_level & ~pin_analog_i;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  reg [NPORT-1:0] port_hit;
  reg [7:0] latch_byte;
  reg [7:0] pin_byte;
  integer p;
  always @* begin
    port_hit = {NPORT{1'b0}};
    latch_byte = `RST_ZERO8;
    pin_byte = `RST_ZERO8;
    for (p = 0; p < NPORT; p = p + 1) begin
      if (sfr_addr_i == `ADDR_PORT0_DATA + p * `ADDR_PORT_STRIDE) begin
        port_hit[p] = 1'b1;
        latch_byte = latch_reg[8*p +: 8];
        pin_byte = pin_read[8*p +: 8];
      end
    end
  end

  // bit write merges the new bit into the latch value of the others
  reg [7:0] bit_merged;
  always @* begin
    bit_merged = latch_byte;
    bit_merged[sfr_bit_sel_i] = sfr_bit_val_i;
  end

  // ----------------------------------------
  // port latches
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      always @(posedge core_clk_i) begin
        if (rst_i) begin
          latch_reg[8*g +: 8] <= `RST_PORT_LATCH;
        end else if (port_hit[g] && sfr_wr_i) begin
          latch_reg[8*g +: 8] <= sfr_wdata_i;
        end else if (port_hit[g] && sfr_bit_wr_i) begin
          latch_reg[8*g +: 8] <= bit_merged;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      crossbar_route_ctrl_b_reg <= `RST_XBAR_CTRL_B;
      port0_match_value_reg <= `RST_MATCH_VAL;
      port0_match_mask_reg <= `RST_MATCH_MASK;
      port1_match_value_reg <= `RST_MATCH_VAL;
      port1_match_mask_reg <= `RST_MATCH_MASK;
      ext_interrupt_enable_2_reg <= `RST_EXT_IE_2;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        `ADDR_XBAR_CTRL_B: crossbar_route_ctrl_b_reg <= sfr_wdata_i;
        `ADDR_P0_MATCH_VAL: port0_match_value_reg <= sfr_wdata_i;
        `ADDR_P0_MATCH_MASK: port0_match_mask_reg <= sfr_wdata_i;
        `ADDR_P1_MATCH_VAL: port1_match_value_reg <= sfr_wdata_i;
        `ADDR_P1_MATCH_MASK: port1_match_mask_reg <= sfr_wdata_i;
        `ADDR_EXT_IE_2: ext_interrupt_enable_2_reg <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg [7:0] rdata_next;
  always @* begin
    case (sfr_addr_i)
      `ADDR_XBAR_CTRL_B: rdata_next = crossbar_route_ctrl_b_reg;
      `ADDR_P0_MATCH_VAL: rdata_next = port0_match_value_reg;
      `ADDR_P0_MATCH_MASK: rdata_next = port0_match_mask_reg;
      `ADDR_P1_MATCH_VAL: rdata_next = port1_match_value_reg;
      `ADDR_P1_MATCH_MASK: rdata_next = port1_match_mask_reg;
      `ADDR_EXT_IE_2: rdata_next = ext_interrupt_enable_2_reg;
      default: rdata_next = sfr_rmw_i ? latch_byte : pin_byte;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `RST_ZERO8;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rdata_next;
    end
  end

  // ----------------------------------------
  // pin drivers and pullups
  // ----------------------------------------
  wire xbar_en = crossbar_route_ctrl_b_reg[`XB_CROSSBAR_EN];
  wire weak_pullup_disable = crossbar_route_ctrl_b_reg[`XB_WEAK_PULLUP_DIS];
  // unclaimed pins take the latch, claimed pins the peripheral
  wire [W-1:0] drive_val = (periph_claim_i & periph_out_i) | (~periph_claim_i & latch_reg);
  reg [W-1:0] oe_next;
  reg [W-1:0] pullup_next;
  always @* begin
    // drivers off while the crossbar is disabled
    oe_next = {W{xbar_en}} & ~pin_analog_i & (pin_pushpull_i | ~drive_val);
    // open-drain pins pull up unless driving low or analog
    pullup_next = {W{~weak_pullup_disable}} & ~pin_pushpull_i & ~pin_analog_i & ~oe_next;
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_out_o <= {W{1'b0}};
      pin_oe_o <= {W{1'b0}};
      pullup_en_o <= {W{1'b0}};
    end else begin
      pin_out_o <= drive_val;
      pin_oe_o <= oe_next;
      pullup_en_o <= pullup_next;
    end
  end

  // ----------------------------------------
  // crossbar routing controls
  // ----------------------------------------
  wire [2:0] cex_cnt = crossbar_route_ctrl_b_reg[`XB_CEX_CNT_HI:`XB_CEX_CNT_LO];
  reg [5:0] cex_next;
  integer c;
  always @* begin
    for (c = 0; c < 6; c = c + 1) begin
      cex_next[c] = (cex_cnt != `XB_CEX_CNT_RSVD) && (cex_cnt > c);
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      crossbar_enable_o <= 1'b0;
      timer0_pin_enable_o <= 1'b0;
      timer1_pin_enable_o <= 1'b0;
      counter_ext_input_enable_o <= 1'b0;
      capture_compare_route_o <= 6'h00;
    end else begin
      crossbar_enable_o <= xbar_en;
      timer0_pin_enable_o <= crossbar_route_ctrl_b_reg[`XB_TIMER0_EN];
      timer1_pin_enable_o <= crossbar_route_ctrl_b_reg[`XB_TIMER1_EN];
      counter_ext_input_enable_o <= crossbar_route_ctrl_b_reg[`XB_ECI_EN];
      capture_compare_route_o <= cex_next;
    end
  end

  // ----------------------------------------
  // port match detection
  // ----------------------------------------
  // compares raw synchronised pins, independent of routing
  wire p0_mismatch = (pin_level[7:0] & port0_match_mask_reg) !=
                     (port0_match_value_reg & port0_match_mask_reg);
  wire p1_mismatch = (pin_level[15:8] & port1_match_mask_reg) !=
                     (port1_match_value_reg & port1_match_mask_reg);
  wire match_event = p0_mismatch | p1_mismatch;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      match_irq_o <= 1'b0;
      osc_wake_o <= 1'b0;
    end else begin
      match_irq_o <= match_event & ext_interrupt_enable_2_reg[`IE2_MATCH_IE];
      osc_wake_o <= match_event;
    end
  end

endmodule

// >>> port_pins_model.sv
// pin model: block driver wins, otherwise the outside source sets the level
`timescale 1ns/1ps
module port_pins_model (
  // block side
  input wire [23:0] out_i,
  input wire [23:0] oe_i,
  // outside side
  input wire [23:0] ext_i,
  output wire [23:0] level_o
);
  assign level_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// >>> port_io_monitor.sv
// assertions on the port i/o block ports
`timescale 1ns/1ps
`include "port_io_map.vh"
module port_io_monitor #(
  parameter NPORT = 3
) (
  // clock, reset and bus
  input wire core_clk_i,
  input wire rst_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_rd_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  // pins and controls
  input wire [8*NPORT-1:0] pin_pushpull_i,
  input wire [8*NPORT-1:0] pin_oe_o,
  input wire [8*NPORT-1:0] pullup_en_o,
  input wire crossbar_enable_o,
  input wire timer0_pin_enable_o,
  input wire timer1_pin_enable_o,
  input wire counter_ext_input_enable_o,
  input wire [5:0] capture_compare_route_o,
  input wire match_irq_o,
  input wire osc_wake_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  a_oe_needs_xbar: assert property (
    $past(!crossbar_enable_o) && !crossbar_enable_o |-> pin_oe_o == '0) else $error("oe without crossbar");
  a_pullup_not_drv: assert property (
    (pullup_en_o & pin_oe_o) == '0) else $error("pullup on driven pin");
  a_pullup_not_pp: assert property (
    (pullup_en_o & $past(pin_pushpull_i)) == '0) else $error("pullup on push-pull pin");
  a_irq_needs_event: assert property (
    match_irq_o |-> osc_wake_o) else $error("irq without match");
  a_route_contig: assert property (
    ((capture_compare_route_o + 6'h01) & capture_compare_route_o) == 6'h00) else $error("route gap");
  a_ctrl_follows: assert property (
    sfr_wr_i && sfr_addr_i == `ADDR_XBAR_CTRL_B ##1 !sfr_wr_i |=>
    {crossbar_enable_o, timer1_pin_enable_o, timer0_pin_enable_o, counter_ext_input_enable_o}
    == $past(sfr_wdata_i[6:3], 2)) else $error("ctrl outputs wrong");
  a_rdata_holds: assert property (
    !$past(sfr_rd_i) |-> $stable(sfr_rdata_o)) else $error("read data moved");
  a_unmapped_zero: assert property (
    sfr_rd_i && sfr_addr_i == 8'h00 |=> sfr_rdata_o == 8'h00) else $error("unmapped read");
  c_irq: cover property (match_irq_o);
  c_wake_only: cover property (osc_wake_o && !match_irq_o);
  c_driving: cover property (|pin_oe_o);
endmodule
bind port_io_latch_and_match port_io_monitor #(.NPORT(NPORT)) u_mon (.*);

// >>> test_port_io_latch_and_match.sv
// self-checking bench for the port i/o block
`timescale 1ns/1ps
`include "port_io_map.vh"
module test_port_io_latch_and_match;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] sfr_addr_i = 8'h00;
  reg sfr_rd_i = 1'b0;
  reg sfr_rmw_i = 1'b0;
  reg sfr_wr_i = 1'b0;
  reg [7:0] sfr_wdata_i = 8'h00;
  reg sfr_bit_wr_i = 1'b0;
  reg [2:0] sfr_bit_sel_i = 3'h0;
  reg sfr_bit_val_i = 1'b0;
  reg [23:0] pin_pushpull_i = 24'h000000;
  reg [23:0] pin_analog_i = 24'h000000;
  reg [23:0] periph_claim_i = 24'h000000;
  reg [23:0] periph_out_i = 24'h000000;
  reg [23:0] ext = 24'h000000;
  reg [7:0] rv;
  wire [7:0] sfr_rdata_o;
  wire [23:0] pin_in_i, pin_out_o, pin_oe_o, pullup_en_o;
  wire crossbar_enable_o, timer0_pin_enable_o, timer1_pin_enable_o, counter_ext_input_enable_o;
  wire [5:0] capture_compare_route_o;
  wire match_irq_o, osc_wake_o;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer i;
  always #50 core_clk_i = ~core_clk_i;
  port_io_latch_and_match DUT (.*);
  port_pins_model pins (.out_i(pin_out_o), .oe_i(pin_oe_o), .ext_i(ext), .level_o(pin_in_i));
  task chk(input string what, input [23:0] exp, input [23:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // k: 0 write, 1 read, 2 latch read, 3 bit write (d[2:0] index, d[3] value)
  task bus(input [1:0] k, input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_bit_sel_i = d[2:0];
      sfr_bit_val_i = d[3];
      sfr_wr_i = (k == 2'd0);
      sfr_rd_i = k[0] ^ k[1];
      sfr_rmw_i = (k == 2'd2);
      sfr_bit_wr_i = (k == 2'd3);
      @(negedge core_clk_i);
      rv = sfr_rdata_o;
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b0;
      sfr_bit_wr_i = 1'b0;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task t_reset;
    begin
      bus(1, `ADDR_XBAR_CTRL_B, 8'h00);
      chk("xbar ctrl", 8'h00, rv);
      bus(2, `ADDR_PORT0_DATA, 8'h00);
      chk("p0 latch", `RST_PORT_LATCH, rv);
      chk("xbar en", 0, crossbar_enable_o);
      bus(1, 8'h00, 8'h00);
      chk("unmapped", 0, rv);
      $display("reset test done");
    end
  endtask
  task t_latch;
    begin
      ext = 24'h0000C3;
      bus(0, `ADDR_PORT0_DATA, 8'h5A);
      bus(0, `ADDR_PORT1_DATA, 8'h3C);
      bus(2, `ADDR_PORT0_DATA, 8'h00);
      chk("p0 latch", 8'h5A, rv);
      bus(2, `ADDR_PORT1_DATA, 8'h00);
      chk("p1 latch", 8'h3C, rv);
      wt(6);
      bus(1, `ADDR_PORT0_DATA, 8'h00);
      chk("p0 pins", 8'hC3, rv);
      bus(3, `ADDR_PORT0_DATA, 8'h08);
      bus(3, `ADDR_PORT0_DATA, 8'h06);
      bus(2, `ADDR_PORT0_DATA, 8'h00);
      chk("p0 bits", 8'h1B, rv);
      chk("oe off", 0, pin_oe_o);
      $display("latch test done");
    end
  endtask
  task t_xbar;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bus(0, `ADDR_XBAR_CTRL_B, 8'h58 | i[7:0]);
        wt(1);
        chk("route", (i == 7) ? 0 : (1 << i) - 1, capture_compare_route_o);
      end
      chk("enables", 4'hB, {crossbar_enable_o, timer1_pin_enable_o, timer0_pin_enable_o, counter_ext_input_enable_o});
      bus(1, `ADDR_XBAR_CTRL_B, 8'h00);
      chk("ctrl rb", 8'h5F, rv);
      pin_pushpull_i = 24'h0000FF;
      wt(6);
      chk("oe", 24'h00C3FF, pin_oe_o);
      chk("out p0", 8'h1B, pin_out_o[7:0]);
      chk("pullup", 24'hFF3C00, pullup_en_o);
      bus(1, `ADDR_PORT0_DATA, 8'h00);
      chk("gpio rb", 8'h1B, rv);
      bus(0, `ADDR_XBAR_CTRL_B, 8'hC0);
      wt(2);
      chk("pud", 0, pullup_en_o);
      $display("crossbar test done");
    end
  endtask
  task t_match;
    begin
      pin_pushpull_i = 24'h000000;
      bus(0, `ADDR_XBAR_CTRL_B, 8'h00);
      ext = 24'h000001;
      bus(0, `ADDR_P0_MATCH_MASK, 8'h01);
      bus(0, `ADDR_P0_MATCH_VAL, 8'h01);
      wt(8);
      chk("no match", 0, osc_wake_o);
      ext = 24'h000000;
      wt(8);
      chk("wake p0", 1, osc_wake_o);
      chk("irq off", 0, match_irq_o);
      bus(0, `ADDR_EXT_IE_2, 8'h02);
      wt(2);
      chk("irq on", 1, match_irq_o);
      ext = 24'h000001;
      wt(8);
      chk("cleared", 0, osc_wake_o);
      bus(0, `ADDR_P1_MATCH_MASK, 8'h80);
      wt(8);
      chk("wake p1", 1, osc_wake_o);
      $display("match test done");
    end
  endtask
  // claimed pins drive the peripheral value, analog pins stay quiet and read zero
  task t_claim;
    begin
      ext = 24'h000081;
      pin_pushpull_i = 24'hFF0000;
      periph_claim_i = 24'h0F0000;
      periph_out_i = 24'h050000;
      pin_analog_i = 24'h000080;
      bus(0, `ADDR_XBAR_CTRL_B, 8'h40);
      wt(6);
      chk("claim out", 8'hF5, pin_out_o[23:16]);
      chk("claim oe", 24'hFFC364, pin_oe_o);
      chk("claim pullup", 24'h003C1B, pullup_en_o);
      bus(1, `ADDR_PORT2_DATA, 8'h00);
      chk("claimed pins", 8'hF5, rv);
      bus(2, `ADDR_PORT2_DATA, 8'h00);
      chk("claimed latch", 8'hFF, rv);
      bus(1, `ADDR_PORT0_DATA, 8'h00);
      chk("analog rb", 8'h01, rv);
      $display("claim test done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  initial begin
    wt(3);
    rst_i = 1'b0;
    t_reset;
    t_latch;
    t_xbar;
    t_match;
    t_claim;
    report_and_stop;
  end
endmodule
